//--- src/ssi_pkg.sv
package ssi_pkg;
	// ==========================================
	// terminal function codes
	localparam int         NUM_TERM    = 8;
	localparam logic [7:0] FN_RATIO1   = 8'h1b;
	localparam logic [7:0] FN_RATIO2   = 8'h1c;
	localparam logic [7:0] FN_OVERHEAT = 8'h22;
	localparam logic [7:0] FN_TEACH    = 8'h23;
	localparam logic [7:0] FN_MODE_SEL = 8'h24;
	localparam logic [7:0] FN_POS_CTRL = 8'h25;
	localparam logic [7:0] FN_TRQ_CTRL = 8'h26;
	localparam logic [7:0] FN_OVR_EN   = 8'h2b;
	localparam logic [7:0] FN_OVR1     = 8'h2c;
	localparam logic [7:0] FN_OVR2     = 8'h2d;
	localparam logic [7:0] FN_OVR4     = 8'h2e;
	localparam logic [7:0] FN_OVR8     = 8'h2f;
	// ==========================================
	// parameter values
	localparam logic [3:0] CM_POS      = 4'h0;
	localparam logic [3:0] CM_SPD      = 4'h1;
	localparam logic [3:0] CM_TRQ      = 4'h2;
	localparam logic [3:0] CM_POS_SPD  = 4'h3;
	localparam logic [3:0] CM_POS_TRQ  = 4'h4;
	localparam logic [3:0] CM_SPD_TRQ  = 4'h5;
	localparam logic [3:0] OM_EXT      = 4'h6;
	localparam logic [3:0] OM_POSN     = 4'h7;
	// ==========================================
	// register offsets
	localparam logic [7:0] REG_FUNC_LO = 8'h00;
	localparam logic [7:0] REG_FUNC_HI = 8'h04;
	localparam logic [7:0] REG_MODE    = 8'h08;
	localparam logic [7:0] REG_WEIGHT  = 8'h0c;
	localparam logic [7:0] REG_MAX_SPD = 8'h10;
	localparam logic [7:0] REG_STATUS  = 8'h14;
	localparam logic [7:0] REG_IRQ_ST  = 8'h18;
	localparam logic [7:0] REG_IRQ_MSK = 8'h1c;
	localparam logic [7:0] REG_COUNTS  = 8'h20;
	localparam logic [7:0] REG_TABLE   = 8'h40;
	// ==========================================
	// fields and reset values
	localparam int          MODE_OP_LSB = 0;
	localparam int          MODE_CM_LSB = 4;
	localparam int          IRQ_OVH     = 0;
	localparam int          IRQ_TEACH   = 1;
	localparam int          IRQ_WREJ    = 2;
	localparam logic [31:0] RST_WEIGHT  = 32'h5028140a;
	localparam logic [15:0] RST_MAX_SPD = 16'hffff;
	localparam logic [9:0]  PCT_UNITY   = 10'h064;
	localparam logic [9:0]  PCT_MAX     = 10'h096;
	localparam logic [19:0] GEAR_COUNTS = 20'h00010;
	localparam int          COUNT_BITS  = 20;
	// ==========================================
	// control state
	typedef enum logic [2:0] {
		ST_POS = 3'b001,
		ST_SPD = 3'b010,
		ST_TRQ = 3'b100
	} ssi_mode_type;
endpackage

//--- src/ssi_sync_edge.sv
`timescale 1ns/1ps
`default_nettype none
// two-stage synchroniser with rising edge from the clean stages
module ssi_sync_edge #(
	parameter int WIDTH = 16
) (
	// clock and reset
	input  wire logic             pclk,
	input  wire logic             presetn,
	input  wire logic             clk_en,
	// raw and cleaned levels
	input  wire logic [WIDTH-1:0] din,
	output logic      [WIDTH-1:0] level,
	output logic      [WIDTH-1:0] rise
);
	// ==========================================
	// stages
	logic [WIDTH-1:0] meta;  // first stage, read only by level
	logic [WIDTH-1:0] last;  // previous clean sample

	// first stage feeds the second and nothing else
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			meta  <= '0;
			level <= '0;
			last  <= '0;
		end else if (clk_en) begin
			meta  <= din;
			level <= meta;
			last  <= level;
		end
	end

	// edge taken from clean samples only
	assign rise = level & ~last;
endmodule
`default_nettype wire

//--- src/ssi_seq_inputs.sv
// ==========================================
// What this block does
// R1: overheat input low raises resistor alarm
// R2: unassigned overheat counts as asserted
// R3: teach edge stores command position
// R4: teaching ignores forced stop and servo-on
// R5: completion on after write, off with teach
// R6: other unassigned functions read as off
// R7: mode select acts under modes 3-5
// R8: extension mode holds position while asserted
// R9: pulses accepted with ratio after position
// R10: one pulse advances sixteen encoder counts
// R11: extension mode holds torque while asserted
// R12: torque only with forward/reverse, sets direction
// R13: override scales speed, capped at maximum
// R14: override skipped in torque, pulse operation
// R15: codes 43..47 assign override functions
// R16: weights default 10/20/40/80, oversum kept
// R17: override off means 100 percent speed
// R18: inputs synchronised, edges from clean samples
`timescale 1ns/1ps
`default_nettype none
module ssi_seq_inputs
	import ssi_pkg::*;
(
	// clock, reset, enable
	input  wire logic        pclk,
	input  wire logic        presetn,
	input  wire logic        clk_en,
	// apb slave
	input  wire logic        psel,
	input  wire logic        penable,
	input  wire logic        pwrite,
	input  wire logic [7:0]  paddr,
	input  wire logic [31:0] pwdata,
	output logic             pready,
	output logic      [31:0] prdata,
	output logic             pslverr,
	// discrete inputs from the sequencer
	input  wire logic [7:0]  sequence_input_terminal,
	input  wire logic        forward_command,
	input  wire logic        reverse_command,
	input  wire logic [3:0]  position_entry_select,
	input  wire logic        servo_on,
	input  wire logic        command_pulse,
	// motion values
	input  wire logic [31:0] command_position,
	input  wire logic [15:0] travel_speed,
	// results
	output logic             resistor_overheat_alarm,
	output logic             overwrite_complete,
	output ssi_mode_type     control_mode,
	output logic             pulse_accept,
	output logic             torque_enable,
	output logic             torque_reverse,
	output logic      [7:0]  override_pct,
	output logic      [15:0] speed_command,
	output logic      [19:0] pulse_counts,
	output logic             irq
);
	// ==========================================
	// input synchronisation
	logic [15:0] raw_in;     // all sequencer pins
	logic [15:0] lvl;        // clean levels
	logic [15:0] rise;       // clean rising edges

	assign raw_in = {position_entry_select, command_pulse,
		servo_on, reverse_command, forward_command,
		sequence_input_terminal};

	// R18: two flops then edge detect
	ssi_sync_edge #(.WIDTH(16)) u_sync (
		.pclk    (pclk),
		.presetn (presetn),
		.clk_en  (clk_en),
		.din     (raw_in),
		.level   (lvl),
		.rise    (rise)
	);

	logic       fwd_lvl;     // forward command
	logic       rev_lvl;     // reverse command
	logic       son_lvl;     // servo on
	logic       pulse_rise;  // command pulse edge
	logic [3:0] entry_sel;   // teach target entry
	assign fwd_lvl    = lvl[8];
	assign rev_lvl    = lvl[9];
	assign son_lvl    = lvl[10];
	assign pulse_rise = rise[11];
	assign entry_sel  = lvl[15:12];

	// ==========================================
	// software registers
	logic [7:0]  func_code [NUM_TERM]; // per-terminal code
	logic [3:0]  op_mode;              // operation mode
	logic [3:0]  ctrl_mode;            // control mode
	logic [7:0]  w1, w2, w4, w8;       // effective weights
	logic [15:0] max_speed;            // speed ceiling
	logic [2:0]  irq_stat;             // sticky events
	logic [2:0]  irq_mask;             // enable per event
	logic [31:0] pos_table [16];       // positioning data

	logic wr_en;   // access-phase write
	logic rd_setup;// setup-phase read
	logic hit;     // address is mapped
	assign wr_en    = psel & penable & pwrite & clk_en;
	assign rd_setup = psel & ~penable & ~pwrite;
	assign hit = (paddr[1:0] == 2'b00) &&
		((paddr <= REG_COUNTS) || (paddr >= REG_TABLE &&
		paddr[7] == 1'b0));

	// proposed weights, checked before use
	logic [9:0] w_sum;
	assign w_sum = 10'(pwdata[7:0]) + 10'(pwdata[15:8]) +
		10'(pwdata[23:16]) + 10'(pwdata[31:24]);
	logic w_reject;  // write over the ceiling
	assign w_reject = wr_en && paddr == REG_WEIGHT &&
		w_sum > PCT_MAX;

	// function codes; code 0 leaves a terminal free
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			for (int i = 0; i < NUM_TERM; i++) begin
				func_code[i] <= 8'h00;
			end
		end else if (wr_en && paddr == REG_FUNC_LO) begin
			for (int i = 0; i < 4; i++) begin
				func_code[i] <= pwdata[8*i +: 8];
			end
		end else if (wr_en && paddr == REG_FUNC_HI) begin
			for (int i = 0; i < 4; i++) begin
				func_code[i+4] <= pwdata[8*i +: 8];
			end
		end
	end

	// mode parameters and speed ceiling
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			op_mode   <= 4'h0;
			ctrl_mode <= CM_POS;
			max_speed <= RST_MAX_SPD;
		end else if (wr_en && paddr == REG_MODE) begin
			op_mode   <= pwdata[MODE_OP_LSB +: 4];
			ctrl_mode <= pwdata[MODE_CM_LSB +: 4];
		end else if (wr_en && paddr == REG_MAX_SPD) begin
			max_speed <= pwdata[15:0];
		end
	end

	// R16: oversum write leaves previous weights
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			{w8, w4, w2, w1} <= RST_WEIGHT;
		end else if (wr_en && paddr == REG_WEIGHT && !w_reject) begin
			{w8, w4, w2, w1} <= pwdata;
		end
	end

	// ==========================================
	// function decode
	// R6: a code on no terminal reads as off
	function automatic logic fn_on(input logic [7:0] code,
		input logic [15:0] v);
		logic r;
		r = 1'b0;
		for (int i = 0; i < NUM_TERM; i++) begin
			if (func_code[i] == code) r = r | v[i];
		end
		return r;
	endfunction

	logic ovh_assigned;  // overheat mapped somewhere
	always_comb begin
		ovh_assigned = 1'b0;
		for (int i = 0; i < NUM_TERM; i++) begin
			if (func_code[i] == FN_OVERHEAT) ovh_assigned = 1'b1;
		end
	end

	logic ovh_lvl, teach_lvl, teach_rise, sel_lvl;
	logic posc_lvl, trqc_lvl, r1_lvl, r2_lvl;
	logic ovr_en, o1, o2, o4, o8;
	// also follows code writes
	always_comb begin
		// R2: unmapped overheat reads as closed contact
		ovh_lvl    = ovh_assigned ? fn_on(FN_OVERHEAT, lvl) : 1'b1;
		teach_lvl  = fn_on(FN_TEACH, lvl);
		teach_rise = fn_on(FN_TEACH, rise);
		sel_lvl    = fn_on(FN_MODE_SEL, lvl);
		posc_lvl   = fn_on(FN_POS_CTRL, lvl);
		trqc_lvl   = fn_on(FN_TRQ_CTRL, lvl);
		r1_lvl     = fn_on(FN_RATIO1, lvl);
		r2_lvl     = fn_on(FN_RATIO2, lvl);
		// R15: override functions by their codes
		ovr_en     = fn_on(FN_OVR_EN, lvl);
		o1         = fn_on(FN_OVR1, lvl);
		o2         = fn_on(FN_OVR2, lvl);
		o4         = fn_on(FN_OVR4, lvl);
		o8         = fn_on(FN_OVR8, lvl);
	end

	// ==========================================
	// overheat alarm
	// R1: open contact raises the alarm
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			resistor_overheat_alarm <= 1'b0;
		end else if (clk_en) begin
			resistor_overheat_alarm <= ~ovh_lvl;
		end
	end

	// ==========================================
	// teaching
	logic teach_go;      // edge in positioning mode
	logic teach_written; // write done last edge
	// R4: no forced-stop or servo-on term here
	assign teach_go = teach_rise && op_mode == OM_POSN;

	// R3: absolute command position into the entry
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			pos_table <= '{default: '0};
		end else if (clk_en && teach_go) begin
			pos_table[entry_sel] <= command_position;
		end
	end

	// R5: on after the write, off with teach
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			teach_written      <= 1'b0;
			overwrite_complete <= 1'b0;
		end else if (clk_en) begin
			teach_written <= teach_go;
			if (!teach_lvl) overwrite_complete <= 1'b0;
			else if (teach_written) overwrite_complete <= 1'b1;
		end
	end

	// ==========================================
	// control mode
	ssi_mode_type next_mode;
	always_comb begin
		next_mode = ST_POS;
		if (op_mode == OM_EXT) begin
			// R8: position held while asserted, wins
			if (posc_lvl) next_mode = ST_POS;
			// R11: torque held while asserted
			else if (trqc_lvl) next_mode = ST_TRQ;
			else next_mode = ST_SPD;
		end else begin
			// R7: selector only under 3, 4, 5
			unique case (ctrl_mode)
				CM_POS_SPD: next_mode = sel_lvl ? ST_SPD : ST_POS;
				CM_POS_TRQ: next_mode = sel_lvl ? ST_TRQ : ST_POS;
				CM_SPD_TRQ: next_mode = sel_lvl ? ST_TRQ : ST_SPD;
				CM_SPD:     next_mode = ST_SPD;
				CM_TRQ:     next_mode = ST_TRQ;
				default:    next_mode = ST_POS;
			endcase
		end
	end

	// mode state register
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			control_mode <= ST_POS;
		end else if (clk_en) begin
			control_mode <= next_mode;
		end
	end

	// R12: torque only on a command, direction by which
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			torque_enable  <= 1'b0;
			torque_reverse <= 1'b0;
		end else if (clk_en) begin
			torque_enable  <= next_mode == ST_TRQ &&
				(fwd_lvl ^ rev_lvl);
			torque_reverse <= rev_lvl & ~fwd_lvl;
		end
	end

	// ==========================================
	// pulse operation
	// R9: ratio input while position control held
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			pulse_accept <= 1'b0;
		end else if (clk_en) begin
			pulse_accept <= op_mode == OM_EXT && posc_lvl &&
				son_lvl && (r1_lvl | r2_lvl);
		end
	end

	// R10: each pulse adds sixteen counts, wraps per turn
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			pulse_counts <= '0;
		end else if (clk_en && pulse_accept && pulse_rise) begin
			pulse_counts <= COUNT_BITS'(pulse_counts + GEAR_COUNTS);
		end
	end

	// ==========================================
	// speed override
	logic [9:0] ovr_sum;  // summed weights
	logic [9:0] eff_pct;  // applied factor
	// R13: sum of the asserted weight bits
	assign ovr_sum = (o1 ? 10'(w1) : 10'h000) +
		(o2 ? 10'(w2) : 10'h000) + (o4 ? 10'(w4) : 10'h000) +
		(o8 ? 10'(w8) : 10'h000);
	// R17: disabled override is unity
	// R14: torque and pulse operation run unscaled
	assign eff_pct = (!ovr_en || next_mode == ST_TRQ ||
		pulse_accept) ? PCT_UNITY : ovr_sum;

	logic [25:0] scaled;  // speed times percent
	logic [25:0] divided; // back to speed units
	assign scaled  = 26'(travel_speed) * 26'(eff_pct);
	assign divided = scaled / 26'(PCT_UNITY);

	// R13: never beyond the speed ceiling
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			override_pct  <= 8'h64;
			speed_command <= '0;
		end else if (clk_en) begin
			override_pct  <= eff_pct[7:0];
			speed_command <= (divided > 26'(max_speed)) ?
				max_speed : divided[15:0];
		end
	end

	// ==========================================
	// interrupts
	logic [2:0] events;    // one-cycle causes
	assign events = {w_reject, teach_written,
		~ovh_lvl & ~resistor_overheat_alarm};

	// sticky status, a set beats a same-cycle clear
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			irq_stat <= 3'h0;
			irq_mask <= 3'h0;
			irq      <= 1'b0;
		end else if (clk_en) begin
			irq_stat <= (irq_stat & ~((wr_en && paddr ==
				REG_IRQ_ST) ? pwdata[2:0] : 3'h0)) | events;
			if (wr_en && paddr == REG_IRQ_MSK) irq_mask <= pwdata[2:0];
			irq <= |(irq_stat & irq_mask);
		end
	end

	// ==========================================
	// apb read path
	logic [31:0] next_rdata;
	always_comb begin
		next_rdata = 32'h0000_0000;
		if (paddr >= REG_TABLE) begin
			next_rdata = pos_table[paddr[5:2]];
		end else begin
			unique case (paddr)
				REG_FUNC_LO: next_rdata = {func_code[3], func_code[2],
					func_code[1], func_code[0]};
				REG_FUNC_HI: next_rdata = {func_code[7], func_code[6],
					func_code[5], func_code[4]};
				REG_MODE:    next_rdata = {24'h0, ctrl_mode, op_mode};
				REG_WEIGHT:  next_rdata = {w8, w4, w2, w1};
				REG_MAX_SPD: next_rdata = {16'h0, max_speed};
				REG_STATUS:  next_rdata = {16'h0, override_pct,
					overwrite_complete, resistor_overheat_alarm,
					pulse_accept, torque_enable, control_mode,
					torque_reverse};
				REG_IRQ_ST:  next_rdata = {29'h0, irq_stat};
				REG_IRQ_MSK: next_rdata = {29'h0, irq_mask};
				REG_COUNTS:  next_rdata = {12'h0, pulse_counts};
				default:     next_rdata = 32'h0000_0000;
			endcase
		end
	end

	// read data captured in setup, shown in access
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			prdata <= '0;
		end else if (clk_en && rd_setup) begin
			prdata <= hit ? next_rdata : 32'h0000_0000;
		end
	end

	// zero-wait slave; frozen clock holds the access
	assign pready  = clk_en;
	assign pslverr = psel & penable & ~hit;

	// ==========================================
	// checks
	default clocking cb @(posedge pclk); endclocking
	default disable iff (!presetn);

	a_overheat_open: assert property ( // R1
		clk_en && ovh_assigned && !ovh_lvl |=> resistor_overheat_alarm)
		else $error("overheat alarm missing");
	a_overheat_unmapped: assert property ( // R2
		clk_en && !ovh_assigned |=> !resistor_overheat_alarm)
		else $error("alarm without overheat terminal");
	a_teach_store: assert property ( // R3
		clk_en && teach_go |=>
		pos_table[$past(entry_sel)] == $past(command_position))
		else $error("teach entry not written");
	a_teach_done: assert property ( // R5
		clk_en && teach_go ##1 clk_en && teach_lvl |=>
		overwrite_complete)
		else $error("completion not raised");
	a_teach_clear: assert property ( // R5
		clk_en && !teach_lvl |=> !overwrite_complete)
		else $error("completion held after teach off");
	a_mode_pos_trq: assert property ( // R7
		clk_en && op_mode != OM_EXT && ctrl_mode == CM_POS_TRQ |=>
		control_mode == ($past(sel_lvl) ? ST_TRQ : ST_POS))
		else $error("mode select wrong");
	a_ext_position: assert property ( // R8
		clk_en && op_mode == OM_EXT && posc_lvl |=>
		control_mode == ST_POS)
		else $error("position control not held");
	a_pulse_gate: assert property ( // R9
		clk_en && !(r1_lvl || r2_lvl) |=> !pulse_accept)
		else $error("pulse accepted without ratio");
	a_gear_step: assert property ( // R10
		clk_en && pulse_accept && pulse_rise |=>
		pulse_counts == COUNT_BITS'($past(pulse_counts) + 20'h00010))
		else $error("pulse step not sixteen");
	a_torque_idle: assert property ( // R12
		clk_en && !fwd_lvl && !rev_lvl |=> !torque_enable)
		else $error("torque without command");
	a_weight_keep: assert property ( // R16
		w_reject |=> $stable({w8, w4, w2, w1}))
		else $error("oversum weights taken");
	a_override_off: assert property ( // R17
		clk_en && !ovr_en |=> override_pct == 8'h64)
		else $error("override not unity when off");
endmodule
`default_nettype wire

//--- sim/ssi_host_model.sv
`timescale 1ns/1ps
`default_nettype none
// ==========================================
// host sequencer model driving the discrete inputs
module ssi_host_model (
	// clock
	input  wire logic        pclk,
	// discrete levels
	output logic      [7:0]  sequence_input_terminal,
	output logic             forward_command,
	output logic             reverse_command,
	output logic      [3:0]  position_entry_select,
	output logic             servo_on,
	output logic             command_pulse,
	// motion values
	output logic      [31:0] command_position,
	output logic      [15:0] travel_speed
);
	// everything off at time zero
	initial begin
		sequence_input_terminal = 8'h00;
		forward_command = 1'b0;
		reverse_command = 1'b0;
		position_entry_select = 4'h0;
		servo_on = 1'b0;
		command_pulse = 1'b0;
		command_position = 32'h0;
		travel_speed = 16'h0;
	end
	// levels change just after an edge
	task automatic pins(input logic [7:0] t, input logic f, input logic r, input logic s);
		@(posedge pclk);
		sequence_input_terminal <= t;
		forward_command <= f;
		reverse_command <= r;
		servo_on <= s;
	endtask
	// teach target, position and unscaled speed
	task automatic motion(input logic [3:0] sel, input logic [31:0] pos, input logic [15:0] spd);
		@(posedge pclk);
		position_entry_select <= sel;
		command_position <= pos;
		travel_speed <= spd;
	endtask
	// two cycles high so the synchroniser misses a pulse only when clk_en is low across it
	task automatic pulses(input int n);
		repeat (n) begin
			@(posedge pclk);
			command_pulse <= 1'b1;
			repeat (2) @(posedge pclk);
			command_pulse <= 1'b0;
			@(posedge pclk);
		end
	endtask
endmodule
`default_nettype wire

//--- sim/tb_ssi_seq_inputs.sv
`timescale 1ns/1ps
`default_nettype none
`define CHK(nm, exp, got) begin total_checks++; if ((got) !== (exp)) begin n_errors++; \
	$display("unexpected %s exp %0h got %0h", nm, exp, got); end end
module tb_ssi_seq_inputs
	import ssi_pkg::*;
;
	// ==========================================
	// clock, reset and apb
	logic        pclk;
	logic        presetn;
	logic        clk_en;
	logic        psel;
	logic        penable;
	logic        pwrite;
	logic [7:0]  paddr;
	logic [31:0] pwdata;
	logic        pready;
	logic [31:0] prdata;
	logic        pslverr;
	// discrete inputs from the host model
	logic [7:0]  sequence_input_terminal;
	logic        forward_command;
	logic        reverse_command;
	logic [3:0]  position_entry_select;
	logic        servo_on;
	logic        command_pulse;
	logic [31:0] command_position;
	logic [15:0] travel_speed;
	// results
	logic         resistor_overheat_alarm;
	logic         overwrite_complete;
	ssi_mode_type control_mode;
	logic         pulse_accept;
	logic         torque_enable;
	logic         torque_reverse;
	logic [7:0]   override_pct;
	logic [15:0]  speed_command;
	logic [19:0]  pulse_counts;
	logic         irq;
	// bookkeeping
	int           n_errors;
	int           total_checks;
	logic [31:0]  rd;
	logic         err;
	// ==========================================
	// instances
	ssi_seq_inputs dut (.pclk, .presetn, .clk_en, .psel, .penable, .pwrite, .paddr, .pwdata, .pready, .prdata,
		.pslverr, .sequence_input_terminal, .forward_command, .reverse_command, .position_entry_select, .servo_on,
		.command_pulse, .command_position, .travel_speed, .resistor_overheat_alarm, .overwrite_complete,
		.control_mode, .pulse_accept, .torque_enable, .torque_reverse, .override_pct, .speed_command,
		.pulse_counts, .irq);
	ssi_host_model host (.pclk, .sequence_input_terminal, .forward_command, .reverse_command,
		.position_entry_select, .servo_on, .command_pulse, .command_position, .travel_speed);
	// 40 mhz clock
	initial pclk = 1'b0;
	always #12.5 pclk = ~pclk;
	// ==========================================
	// verdict, printed once
	task automatic finish_test();
		$display("checks %0d mismatches %0d", total_checks, n_errors);
		if (n_errors == 0 && total_checks > 0) begin
			$display("SIMULATION PASSED");
		end else begin
			$display("SIMULATION FAILED");
		end
		$finish;
	endtask
	// one apb transfer, entered just after a rising edge
	task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
		int n;
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		n = 0;
		do begin
			@(posedge pclk);
			n++;
		end while (pready !== 1'b1 && n < 20);
		if (pready !== 1'b1) begin
			n_errors++;
			$display("unexpected pready timeout");
			finish_test();
		end
		rd = prdata;
		err = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
		@(posedge pclk);
	endtask
	// read and compare
	task automatic rchk(input string nm, input logic [7:0] a, input logic [31:0] exp);
		apb(1'b0, a, 32'h0);
		`CHK(nm, exp, rd)
	endtask
	// function codes for terminals 0..7, byte i is terminal i
	task automatic set_codes(input logic [63:0] c);
		apb(1'b1, REG_FUNC_LO, c[31:0]);
		apb(1'b1, REG_FUNC_HI, c[63:32]);
	endtask
	task automatic cyc(input int n);
		repeat (n) @(posedge pclk);
	endtask
	// bounded wait on the teach completion flag
	task automatic wait_oc(input logic v);
		int n;
		n = 0;
		while (overwrite_complete !== v && n < 20) begin
			@(posedge pclk);
			n++;
		end
		`CHK("overwrite_complete", v, overwrite_complete)
		if (n >= 20) finish_test();
	endtask
	// pins applied, then mode, torque gating and speed compared
	task automatic step(input logic [7:0] t, input logic f, input logic r, input ssi_mode_type m,
		input logic te, input logic tr, input logic [15:0] spd);
		host.pins(t, f, r, 1'b0);
		cyc(4);
		`CHK("control_mode", m, control_mode)
		`CHK("torque_enable", te, torque_enable)
		`CHK("torque_reverse", tr, torque_reverse)
		`CHK("speed_command", spd, speed_command)
	endtask
	// expected state for control mode parameter and select level
	function automatic ssi_mode_type mode_exp(input logic [3:0] cm, input logic s);
		case (cm)
			CM_SPD:     return ST_SPD;
			CM_TRQ:     return ST_TRQ;
			CM_POS_SPD: return s ? ST_SPD : ST_POS;
			CM_POS_TRQ: return s ? ST_TRQ : ST_POS;
			CM_SPD_TRQ: return s ? ST_TRQ : ST_SPD;
			default:    return ST_POS;
		endcase
	endfunction
	// ==========================================
	// hang guard
	initial begin
		repeat (100000) @(posedge pclk);
		n_errors++;
		finish_test();
	end
	// main sequence
	initial begin
		presetn = 1'b0;
		clk_en = 1'b1;
		psel = 1'b0;
		penable = 1'b0;
		pwrite = 1'b0;
		paddr = 8'h00;
		pwdata = 32'h0;
		n_errors = 0;
		total_checks = 0;
		repeat (16) @(posedge pclk);
		presetn <= 1'b1;
		@(posedge pclk);
		// reset values, unassigned overheat reads as on
		`CHK("alarm", 1'b0, resistor_overheat_alarm)
		rchk("weights", REG_WEIGHT, RST_WEIGHT);
		rchk("max_speed", REG_MAX_SPD, 32'h0000ffff);
		rchk("status", REG_STATUS, 32'h00006402);
		apb(1'b0, 8'h24, 32'h0);
		`CHK("pslverr", 1'b1, err)
		$display("test reset done");
		// overheat on terminal 0, contact open raises the alarm
		set_codes(64'h22);
		apb(1'b1, REG_IRQ_MSK, 32'h7);
		cyc(4);
		`CHK("alarm", 1'b1, resistor_overheat_alarm)
		`CHK("irq", 1'b1, irq)
		host.pins(8'h01, 1'b0, 1'b0, 1'b0);
		cyc(4);
		`CHK("alarm", 1'b0, resistor_overheat_alarm)
		apb(1'b1, REG_IRQ_ST, 32'h7);
		set_codes(64'h0);
		host.pins(8'h00, 1'b0, 1'b0, 1'b0);
		cyc(4);
		`CHK("alarm", 1'b0, resistor_overheat_alarm)
		`CHK("irq", 1'b0, irq)
		$display("test overheat done");
		// teach into entry 5 with servo off
		set_codes(64'h2300);
		apb(1'b1, REG_MODE, {24'h0, CM_POS, OM_POSN});
		host.motion(4'h5, 32'h12345678, 16'd1000);
		host.pins(8'h02, 1'b0, 1'b0, 1'b0);
		wait_oc(1'b1);
		rchk("entry5", REG_TABLE + 8'h14, 32'h12345678);
		rchk("entry4", REG_TABLE + 8'h10, 32'h0);
		rchk("irq_st", REG_IRQ_ST, 32'h2);
		host.pins(8'h00, 1'b0, 1'b0, 1'b0);
		wait_oc(1'b0);
		apb(1'b1, REG_IRQ_ST, 32'h7);
		$display("test teach done");
		// every control mode with select off and on
		set_codes(64'h24);
		for (int cm = 0; cm < 6; cm++) begin
			for (int s = 0; s < 2; s++) begin
				apb(1'b1, REG_MODE, {24'h0, 4'(cm), 4'h0});
				host.pins({7'h0, 1'(s)}, 1'b0, 1'b0, 1'b0);
				cyc(4);
				`CHK("control_mode", mode_exp(4'(cm), 1'(s)), control_mode)
			end
		end
		$display("test mode select done");
		// extension mode: t0 position, t1 torque, t2 override on, t3 weight 8
		set_codes(64'h2f2b2625);
		apb(1'b1, REG_MODE, {24'h0, 4'h0, OM_EXT});
		step(8'h00, 1'b0, 1'b0, ST_SPD, 1'b0, 1'b0, 16'd1000);
		step(8'h0c, 1'b0, 1'b0, ST_SPD, 1'b0, 1'b0, 16'd800);
		step(8'h01, 1'b0, 1'b0, ST_POS, 1'b0, 1'b0, 16'd1000);
		step(8'h03, 1'b0, 1'b0, ST_POS, 1'b0, 1'b0, 16'd1000);
		step(8'h0e, 1'b1, 1'b0, ST_TRQ, 1'b1, 1'b0, 16'd1000);
		step(8'h02, 1'b0, 1'b1, ST_TRQ, 1'b1, 1'b1, 16'd1000);
		step(8'h02, 1'b1, 1'b1, ST_TRQ, 1'b0, 1'b0, 16'd1000);
		step(8'h02, 1'b0, 1'b0, ST_TRQ, 1'b0, 1'b0, 16'd1000);
		$display("test extension done");
		// pulse operation: t0 position, t1 ratio one, t2 ratio two
		set_codes(64'h1c1b25);
		host.pins(8'h02, 1'b0, 1'b0, 1'b1);
		cyc(4);
		`CHK("pulse_accept", 1'b0, pulse_accept)
		host.pins(8'h05, 1'b0, 1'b0, 1'b1);
		cyc(4);
		`CHK("pulse_accept", 1'b1, pulse_accept)
		host.pins(8'h03, 1'b0, 1'b0, 1'b1);
		host.pulses(3);
		clk_en <= 1'b0;
		host.pulses(1);
		clk_en <= 1'b1;
		cyc(4);
		`CHK("pulse_counts", 20'h00030, pulse_counts)
		rchk("counts", REG_COUNTS, 32'h30);
		host.pins(8'h01, 1'b0, 1'b0, 1'b1);
		host.pulses(1);
		cyc(4);
		`CHK("pulse_counts", 20'h00030, pulse_counts)
		$display("test pulse done");
		// override bits on t0..t3, enable on t4, speed mode
		set_codes(64'h2b2f2e2d2c);
		apb(1'b1, REG_MODE, {24'h0, CM_SPD, 4'h0});
		for (int b = 0; b < 16; b++) begin
			host.pins({4'h1, 4'(b)}, 1'b0, 1'b0, 1'b0);
			cyc(4);
			`CHK("override_pct", 8'(10 * b), override_pct)
			`CHK("speed_command", 16'(100 * b), speed_command)
		end
		host.pins(8'h0f, 1'b0, 1'b0, 1'b0);
		cyc(4);
		`CHK("speed_command", 16'd1000, speed_command)
		// new weights 5,10,20,40 and a lower ceiling
		apb(1'b1, REG_WEIGHT, 32'h28140a05);
		apb(1'b1, REG_MAX_SPD, 32'd700);
		host.pins(8'h1f, 1'b0, 1'b0, 1'b0);
		cyc(4);
		`CHK("override_pct", 8'd75, override_pct)
		`CHK("speed_command", 16'd700, speed_command)
		// oversum weights are refused and flagged
		apb(1'b1, REG_WEIGHT, 32'h50505050);
		rchk("weights", REG_WEIGHT, 32'h28140a05);
		rchk("irq_st", REG_IRQ_ST, 32'h4);
		`CHK("irq", 1'b1, irq)
		apb(1'b1, REG_IRQ_ST, 32'h4);
		cyc(2);
		`CHK("irq", 1'b0, irq)
		$display("test override done");
		finish_test();
	end
endmodule
`default_nettype wire
